// >>> hw/dpsem_cycle.sv
// Purpose: One pin-level token-space access, write or read
// Assumes: Pins sampled synchronous to clk_sys
// Notes: Select is released after every access
`timescale 1ns/1ps
module dpsem_cycle
    import dpsem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic start,
    input wire logic isWrite,
    input wire logic wrBit,
    input wire logic [DPSEM_IDX_W-1:0] index,
    input wire logic [7:0] setupCycles,
    input wire logic [7:0] strobeCycles,
    output logic done,
    output logic rdBit,
    output logic tokenSpaceSelectN,
    output logic memSelectN,
    output logic outEnableN,
    output logic readWriteN,
    output logic [DPSEM_ADDR_W-1:0] addr,
    output logic [DPSEM_DATA_W-1:0] dataOut,
    output logic dataOutEn,
    input wire logic [DPSEM_DATA_W-1:0] dataIn
);
    typedef enum logic [1:0] {
        CY_IDLE = 2'b00,
        CY_SETUP = 2'b01,
        CY_STROBE = 2'b10,
        CY_HOLD = 2'b11
    } dpsem_cyc_e;

    dpsem_cyc_e stateReg;
    logic [7:0] countReg;
    logic writeReg;

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            stateReg <= CY_IDLE;
            countReg <= 8'h00;
            writeReg <= 1'b0;
            done <= 1'b0;
            rdBit <= 1'b1;
            tokenSpaceSelectN <= 1'b1;
            memSelectN <= 1'b1;
            outEnableN <= 1'b1;
            readWriteN <= 1'b1;
            addr <= '0;
            dataOut <= '0;
            dataOutEn <= 1'b0;
        end
        else if (clkEn)
        begin
            done <= 1'b0;
            unique case (stateReg)
                CY_IDLE:
                begin
                    if (start)
                    begin
                        writeReg <= isWrite;
                        addr <= {{(DPSEM_ADDR_W-DPSEM_IDX_W){1'b0}}, index};
                        // Only bit zero matters to the device; drive it on all lines
                        dataOut <= {DPSEM_DATA_W{wrBit}};
                        tokenSpaceSelectN <= 1'b0; // [R3]
                        memSelectN <= 1'b1; // [R17]
                        countReg <= setupCycles;
                        stateReg <= CY_SETUP;
                    end
                end
                CY_SETUP:
                begin
                    if (countReg <= 8'h01)
                    begin
                        if (writeReg)
                        begin
                            readWriteN <= 1'b0;
                            dataOutEn <= 1'b1;
                        end
                        else
                        begin
                            outEnableN <= 1'b0;
                        end
                        countReg <= strobeCycles;
                        stateReg <= CY_STROBE;
                    end
                    else
                    begin
                        countReg <= countReg - 8'h01;
                    end
                end
                CY_STROBE:
                begin
                    if (countReg <= 8'h01)
                    begin
                        if (!writeReg)
                        begin
                            rdBit <= dataIn[0];
                        end
                        readWriteN <= 1'b1;
                        // Dropping both strobes lets the next read relatch [R12]
                        outEnableN <= 1'b1;
                        tokenSpaceSelectN <= 1'b1;
                        stateReg <= CY_HOLD;
                    end
                    else
                    begin
                        countReg <= countReg - 8'h01;
                    end
                end
                CY_HOLD:
                begin
                    // Data held one cycle past the write strobe
                    dataOutEn <= 1'b0;
                    done <= 1'b1;
                    stateReg <= CY_IDLE;
                end
            endcase
        end
    end
endmodule

// >>> hw/dpsem_host.sv
// Purpose: APB-programmed controller driving one port of a token-flag unit
// Assumes: Device pins synchronous to clk_sys; one controller per port
// Notes: Flags themselves live in the device; this block only sequences accesses
// Overview of operation
// [R1] Device holds eight token flags apart from its memory array.
// [R2] Flags active low: write zero to claim, same port writes one to release.
// [R3] Token space reached with its select low, then a normal static access.
// [R4] Only the three lowest address lines pick the flag.
// [R5] Only data bit zero is sampled on a flag write.
// [R6] Zero on a free flag: writer reads zero, other port reads one.
// [R7] Owner writing one frees the flag unless the other side waits.
// [R8] Non-owner zero is held pending; that port keeps reading one.
// [R9] Pending request takes ownership at once when owner releases.
// [R10] Read returns the flag replicated on every data bit.
// [R11] Read value latched while select and output enable stay active.
// [R12] Polling must drop select or output enable between reads.
// [R13] Claim is write zero then read back; zero means won.
// [R14] After a failed claim keep reading or withdraw by writing one.
// [R15] Simultaneous requests: earlier wins, exact ties go to either side.
// [R16] Software writes one to all eight flags at power-up.
// [R17] Flag access only with memory select high and token select low.
// [R18] Each port has independent request latches; ports are asynchronous.
//
// Decided for this implementation: the register offsets and register access over APB.
`timescale 1ns/1ps
module dpsem_host
    import dpsem_pkg::*;
#(
    parameter int FLAGS = DPSEM_FLAGS
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic tokenSpaceSelectN,
    output logic memSelectN,
    output logic outEnableN,
    output logic readWriteN,
    output logic [DPSEM_ADDR_W-1:0] flagIndex,
    output logic [DPSEM_DATA_W-1:0] dataOut,
    output logic dataOutEn,
    input wire logic [DPSEM_DATA_W-1:0] dataIn
);
    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_WRITE = 3'b001,
        HS_READ = 3'b010,
        HS_WAIT = 3'b011,
        HS_NEXT = 3'b100
    } dpsem_host_e;

    dpsem_host_e stateReg;
    logic [2:0] opReg;
    logic [DPSEM_IDX_W-1:0] idxReg;
    logic busyReg;
    logic doneReg;
    logic wonReg;
    logic lastBitReg;
    logic [FLAGS-1:0] ownedReg;
    logic [7:0] setupReg;
    logic [7:0] strobeReg;
    logic cycStart;
    logic cycWrite;
    logic cycBit;
    logic cycDone;
    logic cycRd;
    logic apbWr;
    logic apbAcc;
    logic cycWriteHeld;

    function automatic logic regHit(input logic [7:0] a, input logic [7:0] ofs);
        regHit = (a == ofs);
    endfunction

    assign apbAcc = psel && penable;
    assign apbWr = apbAcc && pwrite && clkEn;
    // Slave answers in the first access cycle
    assign pready = 1'b1;
    assign pslverr = apbAcc && !(regHit(paddr, DPSEM_OFS_CMD) ||
        regHit(paddr, DPSEM_OFS_STATUS) || regHit(paddr, DPSEM_OFS_RESULT) ||
        regHit(paddr, DPSEM_OFS_TIMING));

    always_comb
    begin
        prdata = 32'h0000_0000;
        if (regHit(paddr, DPSEM_OFS_CMD))
        begin
            prdata[DPSEM_CMD_IDX_LSB +: DPSEM_IDX_W] = idxReg;
            prdata[DPSEM_CMD_OP_LSB +: 3] = opReg;
        end
        else if (regHit(paddr, DPSEM_OFS_STATUS))
        begin
            prdata[DPSEM_ST_BUSY] = busyReg;
            prdata[DPSEM_ST_DONE] = doneReg;
            prdata[DPSEM_ST_WON] = wonReg;
            prdata[DPSEM_ST_OWNED_LSB +: FLAGS] = ownedReg;
        end
        else if (regHit(paddr, DPSEM_OFS_RESULT))
        begin
            prdata = {32{lastBitReg}}; // [R10]
        end
        else if (regHit(paddr, DPSEM_OFS_TIMING))
        begin
            prdata[7:0] = setupReg;
            prdata[15:8] = strobeReg;
        end
    end

    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            setupReg <= DPSEM_SETUP_RST;
            strobeReg <= DPSEM_STROBE_RST;
        end
        else if (apbWr && regHit(paddr, DPSEM_OFS_TIMING))
        begin
            setupReg <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
            strobeReg <= (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
        end
    end

    // Command sequencer
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            stateReg <= HS_IDLE;
            opReg <= DPSEM_OP_READ;
            idxReg <= '0;
            busyReg <= 1'b0;
            doneReg <= 1'b0;
            wonReg <= 1'b0;
            lastBitReg <= 1'b1;
            ownedReg <= '0;
        end
        else if (clkEn)
        begin
            // Done clears on a new command, cmd ignored while busy
            unique case (stateReg)
                HS_IDLE:
                begin
                    if (apbWr && regHit(paddr, DPSEM_OFS_CMD))
                    begin
                        opReg <= pwdata[DPSEM_CMD_OP_LSB +: 3];
                        idxReg <= pwdata[DPSEM_CMD_IDX_LSB +: DPSEM_IDX_W]; // [R4]
                        busyReg <= 1'b1;
                        doneReg <= 1'b0;
                        if (pwdata[DPSEM_CMD_OP_LSB +: 3] == DPSEM_OP_INIT)
                        begin
                            idxReg <= '0;
                        end
                        if (pwdata[DPSEM_CMD_OP_LSB +: 3] == DPSEM_OP_READ)
                        begin
                            stateReg <= HS_READ;
                        end
                        else
                        begin
                            stateReg <= HS_WRITE;
                        end
                    end
                end
                HS_WRITE, HS_READ:
                begin
                    stateReg <= HS_WAIT;
                end
                HS_WAIT:
                begin
                    if (cycDone)
                    begin
                        if (opReg == DPSEM_OP_CLAIM && cycWrite)
                        begin
                            // Read back follows the zero write [R13]
                            stateReg <= HS_READ;
                        end
                        else if (opReg == DPSEM_OP_INIT && idxReg != 3'h7)
                        begin
                            stateReg <= HS_NEXT;
                        end
                        else
                        begin
                            stateReg <= HS_IDLE;
                            busyReg <= 1'b0;
                            doneReg <= 1'b1;
                        end
                        if (!cycWrite)
                        begin
                            lastBitReg <= cycRd;
                            wonReg <= !cycRd; // [R6] [R8]
                            ownedReg[idxReg] <= !cycRd;
                        end
                        else if (cycBit)
                        begin
                            // One releases our token or withdraws pending [R14]
                            ownedReg[idxReg] <= 1'b0;
                        end
                    end
                end
                HS_NEXT:
                begin
                    idxReg <= idxReg + 3'h1; // [R16]
                    stateReg <= HS_WRITE;
                end
                default:
                begin
                    stateReg <= HS_IDLE;
                end
            endcase
        end
    end

    assign cycStart = (stateReg == HS_WRITE) || (stateReg == HS_READ);
    // Direction of the access in flight; held flag covers the wait for done
    assign cycWrite = (stateReg == HS_WRITE) || ((stateReg != HS_READ) && !cycWriteHeld);
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            cycWriteHeld <= 1'b0;
        end
        else if (clkEn && cycStart)
        begin
            cycWriteHeld <= (stateReg == HS_READ);
        end
    end
    // Zero claims, one releases or frees [R2]
    assign cycBit = (opReg == DPSEM_OP_WRITE1) || (opReg == DPSEM_OP_INIT);

    dpsem_cycle u_cycle (
        .clk_sys(clk_sys),
        .reset(reset),
        .clkEn(clkEn),
        .start(cycStart),
        .isWrite(cycWrite),
        .wrBit(cycBit), // [R5]
        .index(idxReg),
        .setupCycles(setupReg),
        .strobeCycles(strobeReg),
        .done(cycDone),
        .rdBit(cycRd),
        .tokenSpaceSelectN(tokenSpaceSelectN),
        .memSelectN(memSelectN),
        .outEnableN(outEnableN),
        .readWriteN(readWriteN),
        .addr(flagIndex),
        .dataOut(dataOut),
        .dataOutEn(dataOutEn),
        .dataIn(dataIn)
    );
endmodule

// >>> hw/dpsem_pkg.sv
// Purpose: Constants for the semaphore port controller
// Assumes: 40 MHz system clock, APB register access
// Notes: Offsets are byte addresses of 32-bit words
package dpsem_pkg;
    localparam int DPSEM_FLAGS = 8;
    localparam int DPSEM_IDX_W = 3;
    localparam int DPSEM_ADDR_W = 13;
    localparam int DPSEM_DATA_W = 16;
    localparam logic [7:0] DPSEM_OFS_CMD = 8'h00;
    localparam logic [7:0] DPSEM_OFS_STATUS = 8'h04;
    localparam logic [7:0] DPSEM_OFS_RESULT = 8'h08;
    localparam logic [7:0] DPSEM_OFS_TIMING = 8'h0C;
    // CMD fields
    localparam int DPSEM_CMD_IDX_LSB = 0;
    localparam int DPSEM_CMD_OP_LSB = 4;
    localparam logic [2:0] DPSEM_OP_READ = 3'h0;
    localparam logic [2:0] DPSEM_OP_WRITE0 = 3'h1;
    localparam logic [2:0] DPSEM_OP_WRITE1 = 3'h2;
    localparam logic [2:0] DPSEM_OP_CLAIM = 3'h3;
    localparam logic [2:0] DPSEM_OP_INIT = 3'h4;
    // STATUS fields
    localparam int DPSEM_ST_BUSY = 0;
    localparam int DPSEM_ST_DONE = 1;
    localparam int DPSEM_ST_WON = 2;
    localparam int DPSEM_ST_OWNED_LSB = 8;
    // Setup and strobe widths, system clocks
    localparam logic [7:0] DPSEM_STROBE_RST = 8'h04;
    localparam logic [7:0] DPSEM_SETUP_RST = 8'h02;
endpackage

// >>> sim/dpsem_dev_model.sv
// Purpose: Behavioural token-flag unit; left port on pins, right port from bench
// Assumes: Pins sampled on clk_sys
// Notes: Write commits when its strobe ends; flags power up owned by left
`timescale 1ns/1ps
module dpsem_dev_model
    import dpsem_pkg::*;
(
    input wire logic clk_sys,
    input wire logic tokenSpaceSelectN,
    input wire logic memSelectN,
    input wire logic outEnableN,
    input wire logic readWriteN,
    input wire logic [DPSEM_ADDR_W-1:0] flagIndex,
    input wire logic [DPSEM_DATA_W-1:0] dataOut,
    input wire logic dataOutEn,
    output logic [DPSEM_DATA_W-1:0] dataIn,
    input wire logic rWr,
    input wire logic rBit,
    input wire logic [2:0] rIdx,
    output logic [7:0] rFlag
);
    logic [7:0] reqL = 8'h00;
    logic [7:0] reqR = 8'hFF;
    logic [7:0] ownL = 8'hFF;
    logic [7:0] ownR = 8'h00;
    logic selA;
    logic wasWr = 1'b0;
    logic wBit;
    logic [2:0] wIdx;
    logic rdOn = 1'b0;
    logic rdLat = 1'b1;
    logic [15:0] idleBus = 16'h0000;
    assign selA = !tokenSpaceSelectN && memSelectN;
    assign rFlag = ~ownR;
    // Zero-latency read: live flag in the first cycle, latched value after
    assign dataIn = (selA && !outEnableN) ?
        {16{rdOn ? rdLat : !ownL[flagIndex[2:0]]}} : idleBus;
    always @(posedge clk_sys)
    begin
        // Latch takes the flag as shown before this edge's updates
        if (selA && !outEnableN && !rdOn)
            rdLat = !ownL[flagIndex[2:0]];
        rdOn = selA && !outEnableN;
        if (wasWr && !(selA && !readWriteN))
            reqL[wIdx] = wBit;
        wasWr = selA && !readWriteN && dataOutEn;
        if (wasWr)
        begin
            wIdx = flagIndex[2:0];
            wBit = dataOut[0];
        end
        if (rWr)
            reqR[rIdx] = rBit;
        for (int i = 0; i < 8; i++)
        begin
            if (ownL[i] && reqL[i])
                ownL[i] = 1'b0;
            if (ownR[i] && reqR[i])
                ownR[i] = 1'b0;
            if (!ownL[i] && !ownR[i] && !reqR[i])
                ownR[i] = 1'b1;
            if (!ownL[i] && !ownR[i] && !reqL[i])
                ownL[i] = 1'b1;
        end
        // Released bus toggles so a stale sample cannot pass
        idleBus <= ~idleBus;
    end
endmodule

// >>> sim/dpsem_host_properties.sv
// Purpose: Pin and register checks on the semaphore port controller
// Assumes: Single clock domain
// Notes: Bound to every dpsem_host
`timescale 1ns/1ps
module dpsem_host_properties
    import dpsem_pkg::*;
#(
    parameter int FLAGS = DPSEM_FLAGS
)
(
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic clkEn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tokenSpaceSelectN,
    input wire logic memSelectN,
    input wire logic outEnableN,
    input wire logic readWriteN,
    input wire logic [DPSEM_ADDR_W-1:0] flagIndex,
    input wire logic [DPSEM_DATA_W-1:0] dataOut,
    input wire logic dataOutEn,
    input wire logic [DPSEM_DATA_W-1:0] dataIn
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    mem_sel_idle_a: assert property (memSelectN)
        else $error("memory select driven low");
    idx_upper_zero_a: assert property (!tokenSpaceSelectN |-> flagIndex[12:3] == '0)
        else $error("upper index bits set during access");
    wr_data_rep_a: assert property (dataOutEn |-> (dataOut == '0 || dataOut == '1))
        else $error("write data not uniform");
    drive_on_write_a: assert property (dataOutEn |-> outEnableN &&
        (!readWriteN || $past(!readWriteN)))
        else $error("data driven outside a write");
    oe_not_write_a: assert property (!outEnableN |-> readWriteN && !tokenSpaceSelectN)
        else $error("output enable outside a read");
    idx_hold_a: assert property (!tokenSpaceSelectN && $past(!tokenSpaceSelectN) |->
        $stable(flagIndex))
        else $error("index moved during access");
    sel_release_a: assert property ($fell(tokenSpaceSelectN) |->
        ##[1:600] tokenSpaceSelectN)
        else $error("select never released");
    result_rep_a: assert property (psel && paddr == DPSEM_OFS_RESULT |->
        (prdata == '0 || prdata == '1))
        else $error("result not replicated");
    cover property (psel && penable && pwrite && paddr == DPSEM_OFS_CMD);
    cover property (!outEnableN && !tokenSpaceSelectN);
    cover property (dataOutEn && !dataOut[0]);
endmodule
bind dpsem_host dpsem_host_properties #(.FLAGS(FLAGS)) dpsem_host_properties_i (
    .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tokenSpaceSelectN(tokenSpaceSelectN), .memSelectN(memSelectN),
    .outEnableN(outEnableN), .readWriteN(readWriteN), .flagIndex(flagIndex),
    .dataOut(dataOut), .dataOutEn(dataOutEn), .dataIn(dataIn));

// >>> sim/test_dpsem_host.sv
// Purpose: Self-checking bench for the semaphore port controller
// Assumes: Right port of the flag unit is driven directly by the bench
// Notes: Random flag indices and timing from a fixed seed
`timescale 1ns/1ps
module test_dpsem_host
    import dpsem_pkg::*;
;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd, tmg;
    logic pready, pslverr, lastErr, selN, memN, oeN, rwN, dEn, rWr = 1'b0, rBit = 1'b1;
    logic [DPSEM_ADDR_W-1:0] idx;
    logic [DPSEM_DATA_W-1:0] dOut, dIn;
    logic [2:0] rIdx = 3'h0;
    logic [2:0] k;
    logic [7:0] rFlag;
    int err_total = 0;
    int n_checks = 0;
    dpsem_host dpsem_host_i (.clk_sys(clk_sys), .reset(reset), .clkEn(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tokenSpaceSelectN(selN), .memSelectN(memN),
        .outEnableN(oeN), .readWriteN(rwN), .flagIndex(idx), .dataOut(dOut),
        .dataOutEn(dEn), .dataIn(dIn));
    dpsem_dev_model dpsem_dev_model_i (.clk_sys(clk_sys), .tokenSpaceSelectN(selN),
        .memSelectN(memN), .outEnableN(oeN), .readWriteN(rwN), .flagIndex(idx),
        .dataOut(dOut), .dataOutEn(dEn), .dataIn(dIn), .rWr(rWr), .rBit(rBit),
        .rIdx(rIdx), .rFlag(rFlag));
    initial
    begin
        forever #12.5 clk_sys = ~clk_sys;
    end
    function automatic logic [31:0] rep(input logic b);
        return {32{b}};
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic run_cmd(input logic [2:0] op, input logic [2:0] i);
        int n;
        apb(1'b1, DPSEM_OFS_CMD, {25'h0, op, 1'b0, i});
        repeat (3) @(posedge clk_sys);
        n = 0;
        // Bounded poll; a hang is reported, not waited out
        do
        begin
            apb(1'b0, DPSEM_OFS_STATUS, 32'h0000_0000);
            n++;
        end while ((rd[DPSEM_ST_BUSY] !== 1'b0 || rd[DPSEM_ST_DONE] !== 1'b1) && n < 500);
        check({31'h0, n < 500}, 32'h0000_0001);
    endtask
    task automatic right_wr(input logic b, input logic [2:0] i);
        @(posedge clk_sys);
        rWr <= 1'b1;
        rBit <= b;
        rIdx <= i;
        @(posedge clk_sys);
        rWr <= 1'b0;
        // Let the model settle before its flag is looked at
        @(posedge clk_sys);
    endtask
    task automatic claim_check(input logic [2:0] i, input logic won);
        run_cmd(DPSEM_OP_CLAIM, i);
        check({31'h0, rd[DPSEM_ST_WON]}, {31'h0, won});
        check({31'h0, rd[DPSEM_ST_OWNED_LSB + i]}, {31'h0, won});
        apb(1'b0, DPSEM_OFS_RESULT, 32'h0000_0000);
        check(rd, rep(!won));
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (60000) @(posedge clk_sys);
        err_total++;
        complete_run();
    end
    initial
    begin
        repeat (16) @(posedge clk_sys);
        reset <= 1'b0;
        k = 3'($urandom(78505));
        apb(1'b0, DPSEM_OFS_TIMING, 32'h0000_0000);
        check(rd, 32'h0000_0402);
        apb(1'b0, 8'h10, 32'h0000_0000);
        check({31'h0, lastErr}, 32'h0000_0001);
        tmg = {16'h0, 8'($urandom_range(6, 1)), 8'($urandom_range(4, 1))};
        apb(1'b1, DPSEM_OFS_TIMING, tmg);
        apb(1'b0, DPSEM_OFS_TIMING, 32'h0000_0000);
        check(rd, tmg);
        run_cmd(DPSEM_OP_INIT, 3'h0);
        for (int i = 0; i < 8; i++)
            right_wr(1'b1, 3'(i));
        $display("test init done");
        repeat (4)
        begin
            k = 3'($urandom_range(7, 0));
            claim_check(k, 1'b1);
            check({31'h0, rFlag[k]}, 32'h0000_0001);
            run_cmd(DPSEM_OP_WRITE1, k);
            right_wr(1'b0, k);
            check({31'h0, rFlag[k]}, 32'h0000_0000);
            right_wr(1'b1, k);
        end
        $display("test free claim done");
        k = 3'($urandom_range(7, 0));
        right_wr(1'b0, k);
        claim_check(k, 1'b0);
        right_wr(1'b1, k);
        run_cmd(DPSEM_OP_READ, k);
        apb(1'b0, DPSEM_OFS_RESULT, 32'h0000_0000);
        check(rd, rep(1'b0));
        right_wr(1'b0, k);
        run_cmd(DPSEM_OP_WRITE1, k);
        check({31'h0, rFlag[k]}, 32'h0000_0000);
        run_cmd(DPSEM_OP_READ, k);
        apb(1'b0, DPSEM_OFS_RESULT, 32'h0000_0000);
        check(rd, rep(1'b1));
        right_wr(1'b1, k);
        run_cmd(DPSEM_OP_WRITE0, k);
        apb(1'b0, DPSEM_OFS_CMD, 32'h0000_0000);
        check(rd, {25'h0, DPSEM_OP_WRITE0, 1'b0, k});
        run_cmd(DPSEM_OP_READ, k);
        apb(1'b0, DPSEM_OFS_RESULT, 32'h0000_0000);
        check(rd, rep(1'b0));
        run_cmd(DPSEM_OP_WRITE1, k);
        check({31'h0, rFlag[k]}, 32'h0000_0001);
        $display("test contention done");
        complete_run();
    end
endmodule
